// file: design/toc_unit.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "toc_regs.svh"

// How it works
// - Both compare values are checked against the counter all the time.
// - A match sets its channel flag on the following timer clock.
// - Enabled flags request interrupts; servicing the interrupt clears them.
// - Writing one to a flag clears it; writing zero keeps it.
// - Compare values are double buffered only in the PWM modes.
// - Buffered compare values move to the active register at top.
// - Software reaches the buffer when buffering, else the active value.
// - Force strobes act like a match in non-PWM modes, without flags.
// - A counter write suppresses every match on the next timer clock.
// - Output states keep their value across mode changes.
// - Output action settings act at once, with no buffering.
// - Reset clears both output states to zero.
// - A nonzero action setting puts the output state on the pin.
// - The pin override ignores the waveform mode.
// - Action setting zero never changes the output state.
// - Action selects set, clear, toggle, or PWM polarity by mode.
// - The mode setting decides the counting sequence; modes 2, 5 and 7 take their top from compare A.
// - Normal mode counts up and wraps from 0xFF to 0x00.
// - Overflow flag sets as the counter reaches zero, except from a top below 0xFF in CTC; servicing clears.
// - The counter may be written at any time in normal mode.
// - A counter write wins over any count or clear in that cycle.
// - Clock source zero stops the counter; it stays accessible.
module toc_unit
   import toc_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   input  wire logic [`TOC_ADDR_W-1:0] i_addr,
   input  wire logic [`TOC_DATA_W-1:0] i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [`TOC_DATA_W-1:0] o_rdata,
   input  wire logic                   i_count_tick,
   input  wire logic [2:0]             i_irq_ack,
   output logic      [2:0]             o_irq,
   input  wire logic [1:0]             i_port_out,
   input  wire logic [1:0]             i_port_dir,
   output logic      [1:0]             o_pin_out,
   output logic      [1:0]             o_pin_oe,
   output logic      [1:0]             o_compare_output
);

   localparam int NCH = 2;

   // Software state.
   logic [1:0]             wgm_lo;
   logic                   wgm_hi;
   logic [2:0]             clk_src;
   logic [1:0]             action   [NCH];
   logic [`TOC_DATA_W-1:0] cmp_buf  [NCH];
   logic [`TOC_DATA_W-1:0] cmp_act  [NCH];
   logic [2:0]             mask;
   logic [2:0]             flags;

   // Counter state.
   logic [`TOC_DATA_W-1:0] counter;
   toc_dir_t               count_dir;
   logic                   block_pending;

   // Next values and decoded terms.
   logic [`TOC_DATA_W-1:0] next_counter;
   toc_dir_t               next_dir;
   logic [2:0]             next_flags;
   logic [2:0]             flag_set;
   logic [2:0]             flag_clr;
   logic [2:0]             wgm;
   toc_kind_t              kind;
   logic                   pwm;
   logic [`TOC_DATA_W-1:0] top_value;
   logic                   at_top;
   logic                   timer_tick;
   logic                   count_go;
   logic                   ovf_evt;
   logic                   bottom_edge;
   logic                   buf_update;
   logic                   wr_ctla;
   logic                   wr_ctlb;
   logic                   wr_count;
   logic                   wr_mask;
   logic                   wr_flags;
   logic [NCH-1:0]         wr_cmp;
   logic [NCH-1:0]         force_hit;
   logic [NCH-1:0]         match;
   logic [NCH-1:0]         hit;
   logic [NCH-1:0]         out_state;
   logic [NCH-1:0]         override;
   logic [`TOC_DATA_W-1:0] ctla_word;
   logic [`TOC_DATA_W-1:0] ctlb_word;
   logic [`TOC_DATA_W-1:0] mask_word;
   logic [`TOC_DATA_W-1:0] flag_word;
   logic [`TOC_DATA_W-1:0] cmp_view [NCH];
   logic [`TOC_DATA_W-1:0] rd_value;
   toc_cycle_t             cyc;
   toc_chan_ctl_t          chan_ctl [NCH];

   // Counting family of each mode setting; 4 and 6 count as normal.
   function automatic toc_kind_t kind_of(input logic [2:0] mode);
      unique case (mode)
         3'h1, 3'h5: kind_of = TOC_PHASE;
         3'h2:       kind_of = TOC_CTC;
         3'h3, 3'h7: kind_of = TOC_FAST;
         default:    kind_of = TOC_NORMAL;
      endcase
   endfunction

   // True for the modes whose top comes from the active compare A value.
   function automatic logic top_from_a(input logic [2:0] mode);
      top_from_a = (mode == 3'h2) || (mode == 3'h5) || (mode == 3'h7);
   endfunction

   // Register write decode.
   assign wr_ctla  = i_wr && (i_addr == `TOC_OFS_CTRL_A);
   assign wr_ctlb  = i_wr && (i_addr == `TOC_OFS_CTRL_B);
   assign wr_count = i_wr && (i_addr == `TOC_OFS_COUNT);
   assign wr_mask  = i_wr && (i_addr == `TOC_OFS_MASK);
   assign wr_flags = i_wr && (i_addr == `TOC_OFS_FLAGS);
   assign wr_cmp[0] = i_wr && (i_addr == `TOC_OFS_CMP_A);
   assign wr_cmp[1] = i_wr && (i_addr == `TOC_OFS_CMP_B);
   assign force_hit[0] = wr_ctlb && i_wdata[`TOC_CTLB_FORCE_A];
   assign force_hit[1] = wr_ctlb && i_wdata[`TOC_CTLB_FORCE_B];

   // Mode decode; the action settings take no part in it.
   assign wgm       = {wgm_hi, wgm_lo};
   assign kind      = kind_of(wgm);
   assign pwm       = (kind == TOC_FAST) || (kind == TOC_PHASE);
   assign top_value = top_from_a(wgm) ? cmp_act[0] : `TOC_MAX;
   assign at_top    = (counter == top_value);

   // Timer clock: the prescaler tick, gated off by clock source zero.
   assign timer_tick = (clk_src != `TOC_CS_STOPPED) && i_count_tick;
   // A counter write takes the tick's place.
   assign count_go   = timer_tick && !wr_count;

   // Top and bottom events of the counting sequence.
   assign bottom_edge = count_go && (kind == TOC_FAST) && at_top;
   assign buf_update  = count_go && at_top &&
                        ((kind == TOC_FAST) ||
                         ((kind == TOC_PHASE) && (count_dir == TOC_UP)));

   // Next counter value and direction.
   always_comb begin
      next_counter = counter;
      next_dir     = count_dir;
      ovf_evt      = 1'b0;
      if (wr_count) begin
         next_counter = i_wdata;
      end else if (count_go) begin
         unique case (kind)
            TOC_NORMAL: begin
               next_counter = counter + `TOC_ONE;
               ovf_evt      = (counter == `TOC_MAX);
            end
            TOC_CTC: begin
               next_counter = at_top ? `TOC_BOTTOM : counter + `TOC_ONE;
               ovf_evt      = (counter == `TOC_MAX);
            end
            TOC_FAST: begin
               next_counter = at_top ? `TOC_BOTTOM : counter + `TOC_ONE;
               ovf_evt      = at_top;
            end
            TOC_PHASE: begin
               if (count_dir == TOC_UP) begin
                  if (at_top) begin
                     next_dir     = TOC_DOWN;
                     next_counter = counter - `TOC_ONE;
                  end else begin
                     next_counter = counter + `TOC_ONE;
                  end
               end else begin
                  if (counter == `TOC_BOTTOM) begin
                     next_dir     = TOC_UP;
                     next_counter = counter + `TOC_ONE;
                  end else begin
                     next_counter = counter - `TOC_ONE;
                     ovf_evt      = (counter == `TOC_ONE);
                  end
               end
            end
         endcase
      end
   end

   // Counter, direction and the match blocking after a counter write.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         counter       <= `TOC_RESET_BYTE;
         count_dir     <= TOC_UP;
         block_pending <= 1'b0;
      end else begin
         counter   <= next_counter;
         count_dir <= next_dir;
         // Held while the timer is stopped.
         if (wr_count) block_pending <= 1'b1;
         else if (timer_tick) block_pending <= 1'b0;
      end
   end

   // Timer clock information common to both channels.
   assign cyc = '{tick:       timer_tick,
                  block:      block_pending,
                  at_bottom:  bottom_edge,
                  count_down: (count_dir == TOC_DOWN),
                  kind:       kind};

   // Both compare channels: buffers, comparators and output states.
   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      assign chan_ctl[ch] = '{action:    action[ch],
                              force_hit: force_hit[ch],
                              toggle_ok: (ch == 0) && wgm_hi};
      assign hit[ch] = timer_tick && match[ch] && !block_pending;
      assign cmp_view[ch] = pwm ? cmp_buf[ch] : cmp_act[ch];
      assign override[ch] = (action[ch] != 2'h0);

      toc_channel #(
         .CNT_W (`TOC_DATA_W)
      ) u_chan (
         .i_clk     (i_clk),
         .i_rst     (i_rst),
         .i_cyc     (cyc),
         .i_ctl     (chan_ctl[ch]),
         .i_counter (counter),
         .i_compare (cmp_act[ch]),
         .o_match   (match[ch]),
         .o_state   (out_state[ch])
      );

      // Compare buffer and active value; direct writes outside PWM.
      // The buffer always takes the write.
      // A mode change keeps the old buffer.
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            cmp_buf[ch] <= `TOC_RESET_BYTE;
            cmp_act[ch] <= `TOC_RESET_BYTE;
         end else begin
            if (wr_cmp[ch]) cmp_buf[ch] <= i_wdata;
            if (wr_cmp[ch] && !pwm) begin
               cmp_act[ch] <= i_wdata;
            end else if (buf_update) begin
               cmp_act[ch] <= cmp_buf[ch];
            end
         end
      end

      // Pin value and direction, registered toward the port logic.
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            o_pin_out[ch] <= 1'b0;
            o_pin_oe[ch]  <= 1'b0;
         end else begin
            o_pin_out[ch] <= override[ch] ? out_state[ch] : i_port_out[ch];
            o_pin_oe[ch]  <= i_port_dir[ch];
         end
      end
   end

   // Flag events; a set in the same cycle as a clear wins.
   assign flag_set[`TOC_BIT_OVF] = ovf_evt;
   assign flag_set[`TOC_BIT_A]   = hit[0];
   assign flag_set[`TOC_BIT_B]   = hit[1];
   assign flag_clr   = (wr_flags ? i_wdata[2:0] : 3'h0) | i_irq_ack;
   assign next_flags = (flags & ~flag_clr) | flag_set;

   // Control registers, mask and flags.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wgm_lo    <= 2'h0;
         wgm_hi    <= 1'b0;
         clk_src   <= 3'h0;
         action[0] <= 2'h0;
         action[1] <= 2'h0;
         mask      <= 3'h0;
         flags     <= 3'h0;
      end else begin
         if (wr_ctla) begin
            wgm_lo    <= i_wdata[`TOC_CTLA_WGM_LSB +: 2];
            action[0] <= i_wdata[`TOC_CTLA_ACT_A_LSB +: 2];
            action[1] <= i_wdata[`TOC_CTLA_ACT_B_LSB +: 2];
         end
         if (wr_ctlb) begin
            wgm_hi  <= i_wdata[`TOC_CTLB_WGM2];
            clk_src <= i_wdata[`TOC_CTLB_CS_LSB +: 3];
         end
         if (wr_mask) mask <= i_wdata[2:0];
         flags <= next_flags;
      end
   end

   // Readable images of the packed registers; force bits read as zero.
   always_comb begin
      ctla_word = `TOC_RESET_BYTE;
      ctlb_word = `TOC_RESET_BYTE;
      ctla_word[`TOC_CTLA_WGM_LSB +: 2]   = wgm_lo;
      ctla_word[`TOC_CTLA_ACT_A_LSB +: 2] = action[0];
      ctla_word[`TOC_CTLA_ACT_B_LSB +: 2] = action[1];
      ctlb_word[`TOC_CTLB_WGM2]           = wgm_hi;
      ctlb_word[`TOC_CTLB_CS_LSB +: 3]    = clk_src;
   end

   assign mask_word = {5'h00, mask};
   assign flag_word = {5'h00, flags};

   // Read selection; unmapped offsets read as zero.
   // Reads have no side effects.
   assign rd_value =
      (i_addr == `TOC_OFS_CTRL_A) ? ctla_word   :
      (i_addr == `TOC_OFS_CTRL_B) ? ctlb_word   :
      (i_addr == `TOC_OFS_COUNT)  ? counter     :
      (i_addr == `TOC_OFS_CMP_A)  ? cmp_view[0] :
      (i_addr == `TOC_OFS_CMP_B)  ? cmp_view[1] :
      (i_addr == `TOC_OFS_MASK)   ? mask_word   :
      (i_addr == `TOC_OFS_FLAGS)  ? flag_word   : `TOC_RESET_BYTE;

   // Read data stands only in the cycle after the read strobe.
   always_ff @(posedge i_clk) begin
      if (i_rst) o_rdata <= `TOC_RESET_BYTE;
      else       o_rdata <= i_rd ? rd_value : `TOC_RESET_BYTE;
   end

   // Interrupt requests and the visible output states.
   // The request lags its flag by one clock.
   // A late acknowledge loses to a new set.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq            <= 3'h0;
         o_compare_output <= 2'h0;
      end else begin
         o_irq            <= flags & mask;
         o_compare_output <= out_state;
      end
   end

endmodule

`default_nettype wire

// file: design/toc_regs.svh
`ifndef TOC_REGS_SVH
`define TOC_REGS_SVH

// Register port geometry.
`define TOC_ADDR_W          3
`define TOC_DATA_W          8

// Register offsets.
`define TOC_OFS_CTRL_A      3'h0
`define TOC_OFS_CTRL_B      3'h1
`define TOC_OFS_COUNT       3'h2
`define TOC_OFS_CMP_A       3'h3
`define TOC_OFS_CMP_B       3'h4
`define TOC_OFS_MASK        3'h5
`define TOC_OFS_FLAGS       3'h6

// Control A fields: output action per channel and low mode bits.
`define TOC_CTLA_ACT_A_LSB  6
`define TOC_CTLA_ACT_B_LSB  4
`define TOC_CTLA_WGM_LSB    0

// Control B fields: force strobes, high mode bit, clock source.
`define TOC_CTLB_FORCE_A    7
`define TOC_CTLB_FORCE_B    6
`define TOC_CTLB_WGM2       3
`define TOC_CTLB_CS_LSB     0

// Mask and flag bit positions.
`define TOC_BIT_OVF         0
`define TOC_BIT_A           1
`define TOC_BIT_B           2

// Values of the counter and the registers.
`define TOC_RESET_BYTE      8'h00
`define TOC_BOTTOM          8'h00
`define TOC_MAX             8'hff
`define TOC_ONE             8'h01
`define TOC_CS_STOPPED      3'h0

`endif

// file: design/toc_pkg.sv
package toc_pkg;

   // Counting direction of the counter.
   typedef enum logic {
      TOC_UP,
      TOC_DOWN
   } toc_dir_t;

   // Family of counting sequence chosen by the mode setting.
   typedef enum logic [1:0] {
      TOC_NORMAL,
      TOC_CTC,
      TOC_FAST,
      TOC_PHASE
   } toc_kind_t;

   // Per timer clock information shared by both channels.
   typedef struct packed {
      logic      tick;
      logic      block;
      logic      at_bottom;
      logic      count_down;
      toc_kind_t kind;
   } toc_cycle_t;

   // Per channel control from the register file.
   typedef struct packed {
      logic [1:0] action;
      logic       force_hit;
      logic       toggle_ok;
   } toc_chan_ctl_t;

endpackage

// file: design/toc_channel.sv
`timescale 1ns/1ps
`default_nettype none

module toc_channel
   import toc_pkg::*;
#(
   parameter int CNT_W = 8
)
(
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire toc_cycle_t       i_cyc,
   input  wire toc_chan_ctl_t    i_ctl,
   input  wire logic [CNT_W-1:0] i_counter,
   input  wire logic [CNT_W-1:0] i_compare,
   output logic                  o_match,
   output logic                  o_state
);

   // The comparator logic cannot serve a one bit counter.
   if (CNT_W < 2) begin : g_bad_width
      $error("toc_channel: CNT_W must be at least 2");
   end

   logic state;
   logic next_state;
   logic hit;
   logic pwm;

   // Action of a match in the non-PWM modes: keep, toggle, clear, set.
   function automatic logic plain_action(input logic [1:0] act,
                                         input logic       cur);
      unique case (act)
         2'h0: plain_action = cur;
         2'h1: plain_action = ~cur;
         2'h2: plain_action = 1'b0;
         2'h3: plain_action = 1'b1;
      endcase
   endfunction

   // Comparator and the qualified match of this timer clock.
   assign o_match = (i_counter == i_compare);
   assign hit     = i_cyc.tick && o_match && !i_cyc.block;
   assign pwm     = (i_cyc.kind == TOC_FAST) || (i_cyc.kind == TOC_PHASE);
   assign o_state = state;

   // Next output state; the action setting is read live, never buffered.
   always_comb begin
      next_state = state;
      if (i_ctl.force_hit && !pwm) begin
         next_state = plain_action(i_ctl.action, state);
      end else if (i_cyc.tick) begin
         unique case (i_cyc.kind)
            TOC_NORMAL,
            TOC_CTC: begin
               if (hit) begin
                  next_state = plain_action(i_ctl.action, state);
               end
            end
            TOC_FAST: begin
               if (i_cyc.at_bottom) begin
                  if (i_ctl.action == 2'h2) next_state = 1'b1;
                  if (i_ctl.action == 2'h3) next_state = 1'b0;
               end else if (hit) begin
                  if (i_ctl.action == 2'h1 && i_ctl.toggle_ok) begin
                     next_state = ~state;
                  end
                  if (i_ctl.action == 2'h2) next_state = 1'b0;
                  if (i_ctl.action == 2'h3) next_state = 1'b1;
               end
            end
            TOC_PHASE: begin
               if (hit) begin
                  if (i_ctl.action == 2'h1 && i_ctl.toggle_ok) begin
                     next_state = ~state;
                  end
                  if (i_ctl.action == 2'h2) next_state = i_cyc.count_down;
                  if (i_ctl.action == 2'h3) next_state = !i_cyc.count_down;
               end
            end
         endcase
      end
   end

   // Output state register; mode changes leave it alone.
   always_ff @(posedge i_clk) begin
      if (i_rst) state <= 1'b0;
      else       state <= next_state;
   end

endmodule

`default_nettype wire

// file: bench/toc_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "toc_regs.svh"

module toc_props (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       i_count_tick,
   input wire logic [2:0] i_irq_ack,
   input wire logic [2:0] o_irq,
   input wire logic [1:0] i_port_out,
   input wire logic [1:0] i_port_dir,
   input wire logic [1:0] o_pin_out,
   input wire logic [1:0] o_pin_oe,
   input wire logic [1:0] o_compare_output
);
   logic [1:0] act_a;
   logic [1:0] act_b;
   logic [2:0] mask;

   // Shadow copies of the action settings and the interrupt mask.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         act_a <= 2'h0;
         act_b <= 2'h0;
         mask  <= 3'h0;
      end else if (i_wr && i_addr == `TOC_OFS_CTRL_A) begin
         act_a <= i_wdata[7:6];
         act_b <= i_wdata[5:4];
      end else if (i_wr && i_addr == `TOC_OFS_MASK) begin
         mask <= i_wdata[2:0];
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   reset_clear_a: assert property (
      $fell(i_rst) |-> o_compare_output == 2'h0 && o_irq == 3'h0)
      else $error("output state not cleared by reset");
   oe_follow_a: assert property (
      !$past(i_rst) |-> o_pin_oe == $past(i_port_dir))
      else $error("pin enable does not follow the direction bit");
   chan_a_pin_a: assert property (
      !$past(i_rst) |-> o_pin_out[0] == (($past(act_a) != 2'h0) ?
         o_compare_output[0] : $past(i_port_out[0])))
      else $error("pin A override wrong");
   chan_b_pin_a: assert property (
      !$past(i_rst) |-> o_pin_out[1] == (($past(act_b) != 2'h0) ?
         o_compare_output[1] : $past(i_port_out[1])))
      else $error("pin B override wrong");
   irq_mask_a: assert property (
      !$past(i_rst) |-> (o_irq & ~$past(mask)) == 3'h0)
      else $error("masked interrupt requested");
   irq_cause_a: assert property (
      !$past(i_rst) && !$past(i_rst, 2) && (o_irq & ~$past(o_irq)) != 3'h0
      |-> $past(i_count_tick, 2) || $past(i_wr && i_addr == `TOC_OFS_MASK, 2))
      else $error("interrupt rose without a timer clock");
   state_cause_a: assert property (
      !$past(i_rst) && !$past(i_rst, 2)
      && o_compare_output != $past(o_compare_output)
      |-> $past(i_count_tick, 2) || $past(i_wr && i_addr == `TOC_OFS_CTRL_B, 2))
      else $error("output state changed without a cause");
   state_hold_a: assert property (
      !$past(i_rst) && !$past(i_rst, 2) && $past(act_a, 2) == 2'h0
      |-> o_compare_output[0] == $past(o_compare_output[0]))
      else $error("output state A changed under action zero");

   cover property ($rose(o_irq[1]));
   cover property (o_compare_output != $past(o_compare_output));
   cover property (o_pin_oe[0] && act_a != 2'h0);
endmodule

bind toc_unit toc_props u_props (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_count_tick(i_count_tick), .i_irq_ack(i_irq_ack), .o_irq(o_irq),
   .i_port_out(i_port_out), .i_port_dir(i_port_dir),
   .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
   .o_compare_output(o_compare_output)
);

`default_nettype wire

// file: bench/toc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module toc_host_model (
   input  wire logic       i_clk,
   input  wire logic [2:0] i_irq,
   input  wire logic [1:0] i_pin_out,
   input  wire logic [1:0] i_pin_oe,
   output logic      [2:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd,
   output logic            o_tick,
   output logic      [2:0] o_irq_ack,
   output logic      [1:0] o_port_out,
   output logic      [1:0] o_port_dir,
   output logic      [1:0] o_pad
);
   int   seed;
   logic svc;
   logic dir_en;

   // Quiet bus, no servicing and pins left as inputs from time zero.
   initial begin
      seed       = 32'h6b41;
      svc        = 1'b0;
      dir_en     = 1'b0;
      {o_addr, o_wdata, o_wr, o_rd, o_tick} = '0;
      {o_irq_ack, o_port_out, o_port_dir} = '0;
   end

   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction

   // One bus cycle; the port pins change every cycle.
   task automatic cyc(input logic wr, input logic rd, input logic [2:0] a,
                      input logic [7:0] d, input logic t);
      o_wr       <= wr;
      o_rd       <= rd;
      o_addr     <= a;
      o_wdata    <= d;
      o_tick     <= t;
      o_port_out <= 2'($random(seed));
      o_port_dir <= 2'($random(seed)) & {2{dir_en}};
      @(posedge i_clk);
   endtask

   // The interrupt service acknowledges a standing request every other cycle.
   always @(posedge i_clk) begin
      o_irq_ack <= svc ? (i_irq & ~o_irq_ack) : 3'h0;
   end

   // A released pin floats up through its pull-up.
   assign o_pad = (i_pin_oe & i_pin_out) | ~i_pin_oe;
endmodule

`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "toc_regs.svh"
`define CHK(nm, got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
      end \
   end

module testbench;
   typedef struct {logic [7:0] data; logic [1:0] st;
                   logic [2:0] irq;} toc_note_t;
   logic       i_clk, i_rst, wr, rd, tick, rd_q, blk, pwm;
   logic [2:0] addr, ack, irq, fl, msk, cs;
   logic [7:0] wdata, rdata, cnt;
   logic [1:0] port_out, port_dir, pin_out, pin_oe, cmp_out, pad, st;
   logic [1:0] act [2];
   logic [7:0] cmp [2];
   toc_note_t  q[$];
   toc_note_t  note;
   int         mismatches, n_tests, i;

   toc_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_count_tick(tick), .i_irq_ack(ack), .o_irq(irq),
      .i_port_out(port_out), .i_port_dir(port_dir), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .o_compare_output(cmp_out));
   toc_host_model cpu (.i_clk(i_clk), .i_irq(irq), .i_pin_out(pin_out),
      .i_pin_oe(pin_oe), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
      .o_rd(rd), .o_tick(tick), .o_irq_ack(ack), .o_port_out(port_out),
      .o_port_dir(port_dir), .o_pad(pad));

   always #50 i_clk = ~i_clk;

   function automatic logic apply(input logic [1:0] a, input logic s);
      case (a)
         2'h1: return ~s;
         2'h2: return 1'b0;
         2'h3: return 1'b1;
         default: return s;
      endcase
   endfunction

   // Reference counter: one timer clock.
   task automatic step(input logic inc = 1'b1);
      if (cs != 3'h0) begin
         for (int b = 0; b < 2; b++) begin
            if (!blk && cnt == cmp[b]) begin
               fl[b+1] = 1'b1;
               st[b]   = apply(act[b], st[b]);
            end
         end
         blk = 1'b0;
         cnt = cnt + inc;
         if (inc && cnt == 8'h00) fl[0] = 1'b1;
      end
   endtask

   task automatic wreg(input logic [2:0] a, input logic [7:0] d,
                       input logic t = 1'b0);
      if (t) step(1'b0);
      case (a)
         `TOC_OFS_CTRL_A: begin
            act[0] = d[7:6];
            act[1] = d[5:4];
            pwm    = d[0];
         end
         `TOC_OFS_CTRL_B: begin
            cs = d[2:0];
            if (!pwm && d[7]) st[0] = apply(act[0], st[0]);
            if (!pwm && d[6]) st[1] = apply(act[1], st[1]);
         end
         `TOC_OFS_COUNT: {cnt, blk} = {d, 1'b1};
         `TOC_OFS_CMP_A: if (!pwm) cmp[0] = d;
         `TOC_OFS_CMP_B: if (!pwm) cmp[1] = d;
         `TOC_OFS_MASK: msk = d[2:0];
         `TOC_OFS_FLAGS: fl = fl & ~d[2:0];
         default: ;
      endcase
      cpu.cyc(1'b1, 1'b0, a, d, t);
   endtask

   task automatic rreg(input logic [2:0] a, input logic [7:0] e);
      q.push_back('{e, st, fl & msk});
      cpu.cyc(1'b0, 1'b1, a, 8'h00, 1'b0);
   endtask

   task automatic run(input int n, input logic t = 1'b1);
      repeat (n) begin
         if (t) step();
         cpu.cyc(1'b0, 1'b0, 3'h0, 8'h00, t);
      end
   endtask

   task automatic conclude();
      $display("TB: %0d mismatches in %0d comparisons", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Takes the oldest note when read data appear.
   always @(posedge i_clk) begin
      if (rd_q) begin
         note = q.pop_front();
         `CHK("read data", rdata, note.data)
         `CHK("output state", cmp_out, note.st)
         `CHK("interrupt", irq, note.irq)
      end
      rd_q <= rd;
   end

   // Cuts a hang short.
   initial begin
      #(100 * 20000);
      mismatches++;
      conclude();
   end

   // Main sequence.
   initial begin
      {i_clk, rd_q, blk, pwm, fl, msk, cs, cnt, st} = '0;
      {act[0], act[1], cmp[0], cmp[1]} = '0;
      {mismatches, n_tests} = '0;
      i_rst = 1'b1;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      for (i = 0; i < 8; i++) rreg(i[2:0], 8'h00);
      wreg(`TOC_OFS_CTRL_A, 8'hd0);
      wreg(`TOC_OFS_CTRL_B, 8'hc0);
      wreg(`TOC_OFS_CTRL_B, 8'h40);
      cpu.dir_en = 1'b1;
      rreg(`TOC_OFS_CTRL_B, 8'h00);
      rreg(`TOC_OFS_FLAGS, 8'h00);
      wreg(`TOC_OFS_CMP_A, 8'h10);
      wreg(`TOC_OFS_CTRL_A, 8'h03);
      wreg(`TOC_OFS_CMP_A, 8'h20);
      wreg(`TOC_OFS_CTRL_B, 8'hc0);
      rreg(`TOC_OFS_CMP_A, 8'h20);
      wreg(`TOC_OFS_CTRL_A, 8'h00);
      rreg(`TOC_OFS_CMP_A, 8'h10);
      wreg(`TOC_OFS_CTRL_A, 8'h03);
      wreg(`TOC_OFS_COUNT, 8'hff);
      wreg(`TOC_OFS_CTRL_B, 8'h01);
      run(1);
      cmp[0] = 8'h20; // Buffered value moves at the top.
      wreg(`TOC_OFS_CTRL_B, 8'h00);
      wreg(`TOC_OFS_CTRL_A, 8'h00);
      rreg(`TOC_OFS_CMP_A, 8'h20);
      rreg(`TOC_OFS_FLAGS, {5'h0, fl});
      wreg(`TOC_OFS_CMP_A, 8'h40);
      wreg(`TOC_OFS_COUNT, 8'h40);
      run(3);
      rreg(`TOC_OFS_COUNT, 8'h40);
      wreg(`TOC_OFS_CTRL_B, 8'h01);
      run(2);
      rreg(`TOC_OFS_FLAGS, {5'h0, fl});
      wreg(`TOC_OFS_MASK, 8'h02);
      for (i = 0; i < 8; i++) begin
         cpu.svc = i[0];
         wreg(`TOC_OFS_CMP_A, cpu.rnd());
         wreg(`TOC_OFS_CMP_B, cpu.rnd());
         wreg(`TOC_OFS_CTRL_A, {i[1:0], ~i[1:0], 4'h0});
         wreg(`TOC_OFS_COUNT, cpu.rnd());
         run(cpu.rnd());
         wreg(`TOC_OFS_COUNT, cpu.rnd(), 1'b1);
         run(cpu.rnd());
         run(6, 1'b0);
         if (cpu.svc) fl = fl & ~msk;
         rreg(`TOC_OFS_COUNT, cnt);
         wreg(`TOC_OFS_FLAGS, 8'h00);
         rreg(`TOC_OFS_FLAGS, {5'h0, fl});
         wreg(`TOC_OFS_FLAGS, 8'h07);
         rreg(`TOC_OFS_FLAGS, 8'h00);
      end
      run(3, 1'b0);
      conclude();
   end
endmodule

`default_nettype wire
